// *** dtc_top.sv ***
// Purpose: two 16-bit timer/counters behind an Avalon-MM slave
// Assumes: count pins are asynchronous to i_clk_sys
// Notes: every access costs one wait cycle
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_sys_rst,
  // avalon-mm slave
  input  wire logic [dtc_pkg::AW-1:0]   i_avs_address,
  input  wire logic                     i_avs_read,
  input  wire logic                     i_avs_write,
  input  wire logic [3:0]               i_avs_byteenable,
  input  wire logic [dtc_pkg::DW-1:0]   i_avs_writedata,
  output logic      [dtc_pkg::DW-1:0]   o_avs_readdata,
  output logic                          o_avs_waitrequest,
  // external count and gate pins
  input  wire logic                     i_count_input_0,
  input  wire logic                     i_count_input_1,
  // interrupt service
  input  wire logic                     i_irq_ack_0,
  input  wire logic                     i_irq_ack_1,
  output logic                          o_ovf_flag_0,
  output logic                          o_ovf_flag_1
);
  dtc_pkg::dtc_bus_t   bus_reg;
  logic                wait_reg;
  logic [dtc_pkg::DW-1:0] rdata_reg;
  logic [7:0]          rd_mux;
  logic [7:0]          wr_idx;
  logic [7:0]          wdata;
  logic                wr_fire;
  logic [7:0]          mode_reg;
  logic [1:0]          run_reg;
  logic [1:0]          flag_reg;
  logic [1:0]          flag_set;
  logic [3:0]          mc_cnt_reg;
  logic                mc_tick;
  logic [1:0]          pin;
  logic                split0;

  assign pin     = {i_count_input_1, i_count_input_0};
  assign wr_idx  = i_avs_address[dtc_pkg::AW-1:2];
  assign wdata   = i_avs_writedata[7:0];
  assign wr_fire = i_avs_write & ~wait_reg & i_avs_byteenable[0];
  assign mc_tick = (mc_cnt_reg == dtc_pkg::MC_LAST);

  // bus handshake: drop waitrequest for one cycle per request
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bus_reg  <= dtc_pkg::BUS_WAIT;
      wait_reg <= 1'b1;
    end else if (bus_reg == dtc_pkg::BUS_WAIT) begin
      if (i_avs_read | i_avs_write) begin
        bus_reg  <= dtc_pkg::BUS_ACK;
        wait_reg <= 1'b0;
      end
    end else begin
      bus_reg  <= dtc_pkg::BUS_WAIT;
      wait_reg <= 1'b1;
    end
  end

  // read data is latched as waitrequest falls so it stands at the ack edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_reg <= '0;
    end else if (i_avs_read & wait_reg & (bus_reg == dtc_pkg::BUS_WAIT)) begin
      rdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  always_comb begin
    case (wr_idx)
      dtc_pkg::IDX_RUN:  rd_mux = {flag_reg[1], run_reg[1], flag_reg[0], run_reg[0], 4'h0};
      dtc_pkg::IDX_MODE: rd_mux = mode_reg;
      dtc_pkg::IDX_LO0:  rd_mux = g_unit[0].lo_reg;
      dtc_pkg::IDX_LO1:  rd_mux = g_unit[1].lo_reg;
      dtc_pkg::IDX_HI0:  rd_mux = g_unit[0].hi_reg;
      dtc_pkg::IDX_HI1:  rd_mux = g_unit[1].hi_reg;
      default:           rd_mux = 8'h00;
    endcase
  end

  // mode register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_reg <= dtc_pkg::MODE_RST;
    end else if (wr_fire && wr_idx == dtc_pkg::IDX_MODE) begin
      mode_reg <= wdata;
    end
  end

  // run-enable bits; count bytes are not touched here
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      run_reg <= dtc_pkg::RUN_RST;
    end else if (wr_fire && wr_idx == dtc_pkg::IDX_RUN) begin
      run_reg <= {wdata[dtc_pkg::RC_RUN1], wdata[dtc_pkg::RC_RUN0]};
    end
  end

  // machine cycle prescaler, one tick per 12 core clocks
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mc_cnt_reg <= 4'h0;
    end else if (mc_tick) begin
      mc_cnt_reg <= 4'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
    end
  end

  assign split0 = (mode_reg[1:0] == dtc_pkg::MODE_SPLIT);

  // unit 1 flag follows the split high byte of unit 0 while it is borrowed
  assign flag_set[0] = g_unit[0].ovf_lo;
  assign flag_set[1] = split0 ? g_unit[0].ovf_hi : g_unit[1].ovf_lo;

  // hardware set beats a software clear or an ack in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      flag_reg <= dtc_pkg::FLAG_RST;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (flag_set[k]) begin
          flag_reg[k] <= 1'b1;
        end else if (k == 0 ? i_irq_ack_0 : i_irq_ack_1) begin
          flag_reg[k] <= 1'b0;
        end else if (wr_fire && wr_idx == dtc_pkg::IDX_RUN) begin
          flag_reg[k] <= wdata[k == 0 ? dtc_pkg::RC_FLAG0 : dtc_pkg::RC_FLAG1];
        end
      end
    end
  end

  for (genvar n = 0; n < 2; n++) begin : g_unit
    logic [7:0]          lo_reg;
    logic [7:0]          hi_reg;
    logic [7:0]          lo_next;
    logic [7:0]          hi_next;
    logic                s1_reg;
    logic                s2_reg;
    logic                samp_reg;
    logic                prev_reg;
    logic [3:0]          ctl;
    dtc_pkg::dtc_mode_t  mode;
    logic                edge_ev;
    logic                inc;
    logic                ovf_lo;
    logic                ovf_hi;
    logic                wr_lo;
    logic                wr_hi;

    assign ctl   = mode_reg[n*dtc_pkg::UNIT_STRIDE +: 4];
    assign mode  = dtc_pkg::dtc_mode_t'(ctl[dtc_pkg::FLD_MODE +: 2]);
    assign wr_lo = wr_fire && wr_idx == (n == 0 ? dtc_pkg::IDX_LO0 : dtc_pkg::IDX_LO1);
    assign wr_hi = wr_fire && wr_idx == (n == 0 ? dtc_pkg::IDX_HI0 : dtc_pkg::IDX_HI1);

    // two-flop synchroniser on the pin
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        s1_reg <= 1'b1;
        s2_reg <= 1'b1;
      end else begin
        s1_reg <= pin[n];
        s2_reg <= s1_reg;
      end
    end

    // sampling once per machine cycle: a level shorter than that may be missed
    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        samp_reg <= 1'b1;
        prev_reg <= 1'b1;
      end else if (mc_tick) begin
        samp_reg <= s2_reg;
        prev_reg <= samp_reg;
      end
    end

    // edge counted on the tick after the low sample: two machine cycles
    assign edge_ev = mc_tick & prev_reg & ~samp_reg;
    assign inc = (ctl[dtc_pkg::FLD_CT] ? edge_ev : mc_tick)
               & run_reg[n]
               & (~ctl[dtc_pkg::FLD_GATE] | s2_reg);

    always_comb begin
      lo_next = lo_reg;
      hi_next = hi_reg;
      ovf_lo  = 1'b0;
      ovf_hi  = 1'b0;
      case (mode)
        dtc_pkg::MODE_13: begin
          if (inc) begin
            lo_next[4:0] = lo_reg[4:0] + 5'h01;
            if (lo_reg[4:0] == dtc_pkg::PRESC_MAX) begin
              hi_next = hi_reg + 8'h01;
              ovf_lo  = (hi_reg == dtc_pkg::BYTE_MAX);
            end
          end
        end
        dtc_pkg::MODE_16: begin
          if (inc) begin
            {hi_next, lo_next} = {hi_reg, lo_reg} + 16'h0001;
            ovf_lo = (hi_reg == dtc_pkg::BYTE_MAX) && (lo_reg == dtc_pkg::BYTE_MAX);
          end
        end
        dtc_pkg::MODE_RLD: begin
          if (inc) begin
            if (lo_reg == dtc_pkg::BYTE_MAX) begin
              lo_next = hi_reg;
              ovf_lo  = 1'b1;
            end else begin
              lo_next = lo_reg + 8'h01;
            end
          end
        end
        default: begin
          // unit 1 holds here; unit 0 splits into two byte counters
          if (n == 0) begin
            if (inc) begin
              lo_next = lo_reg + 8'h01;
              ovf_lo  = (lo_reg == dtc_pkg::BYTE_MAX);
            end
            if (mc_tick & run_reg[1]) begin
              hi_next = hi_reg + 8'h01;
              ovf_hi  = (hi_reg == dtc_pkg::BYTE_MAX);
            end
          end
        end
      endcase
      // a software write to a byte wins over counting in that cycle
      if (wr_lo) begin
        lo_next = wdata;
      end
      if (wr_hi) begin
        hi_next = wdata;
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
        lo_reg <= dtc_pkg::CNT_RST;
        hi_reg <= dtc_pkg::CNT_RST;
      end else begin
        lo_reg <= lo_next;
        hi_reg <= hi_next;
      end
    end
  end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_ovf_flag_0      = flag_reg[0];
  assign o_ovf_flag_1      = flag_reg[1];

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_req;
    (i_avs_read | i_avs_write) && wait_reg && (bus_reg == dtc_pkg::BUS_WAIT);
  endsequence
  sequence s_ack;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_ack_a: assert property (s_req |=> s_ack)
    else $error("bus request not answered in one cycle");
  mc_period_a: assert property (mc_tick |-> ##12 mc_tick)
    else $error("machine cycle not 12 clocks");
  mc_gap_a: assert property (mc_tick |=> !mc_tick [*8])
    else $error("machine tick too early");
  mode_reset_a: assert property ($past(i_sys_rst) |-> mode_reg == dtc_pkg::MODE_RST)
    else $error("mode register not zero after reset");
  run_hold_a: assert property (!run_reg[0] && !wr_fire |=> $stable(g_unit[0].lo_reg))
    else $error("unit 0 low byte moved while stopped");
  gate_block_a: assert property (g_unit[0].ctl[dtc_pkg::FLD_GATE] && !g_unit[0].s2_reg
                                 |-> !g_unit[0].inc)
    else $error("gated unit counted with input low");
  edge_count_a: assert property (g_unit[1].ctl[dtc_pkg::FLD_CT] && g_unit[1].inc
                                 |-> g_unit[1].prev_reg && !g_unit[1].samp_reg)
    else $error("counter stepped without a falling edge");
  timer16_a: assert property (g_unit[0].mode == dtc_pkg::MODE_16 && !g_unit[0].ctl[dtc_pkg::FLD_CT]
                              && !g_unit[0].ctl[dtc_pkg::FLD_GATE] && run_reg[0] && mc_tick && !wr_fire
                              |=> {g_unit[0].hi_reg, g_unit[0].lo_reg}
                                  == $past({g_unit[0].hi_reg, g_unit[0].lo_reg}) + 16'h0001)
    else $error("16-bit timer did not step by one");
  reload_a: assert property (g_unit[1].mode == dtc_pkg::MODE_RLD && g_unit[1].inc && !wr_fire && !split0
                             && g_unit[1].lo_reg == dtc_pkg::BYTE_MAX
                             |=> g_unit[1].lo_reg == $past(g_unit[1].hi_reg) && flag_reg[1])
    else $error("auto-reload failed");
  unit1_hold_a: assert property (g_unit[1].mode == dtc_pkg::MODE_SPLIT && !wr_fire
                                 |=> $stable(g_unit[1].lo_reg) && $stable(g_unit[1].hi_reg))
    else $error("unit 1 moved in mode 3");
  ovf_flag_a: assert property (flag_set[0] |=> flag_reg[0])
    else $error("overflow did not set flag");
  ack_clear_a: assert property (i_irq_ack_1 && !flag_set[1] |=> !flag_reg[1])
    else $error("ack did not clear flag");
endmodule // dtc_top
`default_nettype wire

// *** dtc_pkg.sv ***
// Purpose: constants for the dual timer/counter block
// Assumes: one 25 MHz core clock, synchronous active-high reset
// Notes: register index times four gives the byte address
//
// Overview of operation
// - Two independent 16-bit units, 0 and 1, each timer or event counter.
// - Timer operation counts one step per machine cycle of 12 core clocks.
// - Counter operation steps on a high-to-low edge of the unit's count input.
// - Edge recognition takes two machine cycles; top rate is 1/24 of the core clock.
// - A unit counts only while its run-enable bit is set.
// - Gate-qualify bit set: count only while run-enable set and input high.
// - Count-select bit 1 picks falling-edge counting, 0 picks machine cycles.
// - Mode field is bits 5:4 for unit 1 and 1:0 for unit 0.
// - Mode 00 13-bit, 01 16-bit, 10 8-bit auto-reload, 11 special.
// - Unit 1 in mode 3 stops and holds its count.
// - Unit 0 in mode 3 splits into two independent 8-bit counters.
// - Wrap from all ones to zero sets the unit's overflow flag.
// - Setting run-enable leaves count bytes untouched; counting resumes.
// - Mode register resets to zero.
// - Mode 2 low-byte overflow sets flag and reloads low from high.
// - Unit 0 mode 3 high byte times cycles with unit 1 run and flag.
// - Overflow flags clear by software or on interrupt service.
package dtc_pkg;
  localparam int unsigned MC_DIV = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);
  localparam int unsigned AW = 10;
  localparam int unsigned DW = 32;
  localparam logic [7:0] IDX_RUN  = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_LO0  = 8'h8a;
  localparam logic [7:0] IDX_LO1  = 8'h8b;
  localparam logic [7:0] IDX_HI0  = 8'h8c;
  localparam logic [7:0] IDX_HI1  = 8'h8d;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] RUN_RST  = 2'h0;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam int unsigned UNIT_STRIDE = 4;
  localparam int unsigned FLD_GATE = 3;
  localparam int unsigned FLD_CT   = 2;
  localparam int unsigned FLD_MODE = 0;
  localparam int unsigned RC_FLAG1 = 7;
  localparam int unsigned RC_RUN1  = 6;
  localparam int unsigned RC_FLAG0 = 5;
  localparam int unsigned RC_RUN0  = 4;
  localparam logic [4:0] PRESC_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX  = 8'hff;
  typedef enum logic [1:0] {
    MODE_13    = 2'b00,
    MODE_16    = 2'b01,
    MODE_RLD   = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_t;
  typedef enum logic {
    BUS_WAIT = 1'b0,
    BUS_ACK  = 1'b1
  } dtc_bus_t;
endpackage

// *** dtc_pin_model.sv ***
// Purpose: external event source driving one count/gate pin
// Assumes: pin idles high, so a pulse is a low excursion
// Notes: levels held two machine cycles so each is caught by the once-per-machine-cycle sample
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
  // clock
  input  wire logic i_clk_sys,
  // pin
  output var  logic o_pin
);
  initial o_pin = 1'b1;
  task automatic set_level(input logic v);
    @(posedge i_clk_sys) o_pin <= v;
  endtask
  // each level held 24 clocks, well over one machine cycle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk_sys) o_pin <= 1'b0;
      repeat (24) @(posedge i_clk_sys);
      o_pin <= 1'b1;
      repeat (23) @(posedge i_clk_sys);
    end
  endtask
endmodule // dtc_pin_model
`default_nettype wire

// *** dtc_top_test.sv ***
// Purpose: self-checking bench for the dual timer/counter
// Assumes: avalon slave answers after one wait cycle, master never counts on it
// Notes: tick phase is unknown to the bench, so timing checks use windows
`timescale 1ns/100ps
`default_nettype none
module dtc_top_test;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [dtc_pkg::AW-1:0]   addr = '0;
  logic                     rd = 1'b0;
  logic                     wr = 1'b0;
  logic [3:0]               be = 4'hf;
  logic [dtc_pkg::DW-1:0]   wdata = '0;
  logic [dtc_pkg::DW-1:0]   rdata;
  logic                     wreq;
  logic                     ack0 = 1'b0;
  logic                     ack1 = 1'b0;
  logic                     pin0;
  logic                     pin1;
  logic                     f0;
  logic                     f1;
  logic [7:0]               q;
  int                       n;
  int                       compares = 0;
  int                       miscompares = 0;

  initial forever #20 clk = ~clk;

  dtc_pin_model pm0 (.i_clk_sys(clk), .o_pin(pin0));
  dtc_pin_model pm1 (.i_clk_sys(clk), .o_pin(pin1));
  dtc_top dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(be), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_count_input_0(pin0), .i_count_input_1(pin1),
    .i_irq_ack_0(ack0), .i_irq_ack_1(ack1), .o_ovf_flag_0(f0), .o_ovf_flag_1(f1));

  task automatic wrap_up();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail_now();
    miscompares++;
    wrap_up();
  endtask
  // request held until waitrequest is seen low; data taken at that edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 40) fail_now();
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_flag(input bit u, input int lim);
    n = 0;
    while ((u ? f1 : f0) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) fail_now();
  endtask
  // stop first so the count bytes load while idle, then start
  task automatic setup(input logic [7:0] m, lo_i, lo, hi_i, hi, run);
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    wreg(dtc_pkg::IDX_MODE, m);
    wreg(lo_i, lo);
    wreg(hi_i, hi);
    wreg(dtc_pkg::IDX_RUN, run);
  endtask

  task automatic s_reset();
    bus(1'b0, dtc_pkg::IDX_MODE, 8'h00, q);
    chk(q, 8'h00, "mode after reset");
    @(posedge clk) be <= 4'h0;
    wreg(dtc_pkg::IDX_MODE, 8'h01);
    be <= 4'hf;
    bus(1'b0, dtc_pkg::IDX_MODE, 8'h00, q);
    chk(q, 8'h00, "write without lane 0 ignored");
    bus(1'b0, dtc_pkg::IDX_RUN, 8'h00, q);
    chk(q, 8'h00, "run after reset");
    bus(1'b0, 8'h80, 8'h00, q);
    chk(q, 8'h00, "unmapped read");
  endtask
  task automatic s_timer16();
    setup(8'h01, dtc_pkg::IDX_LO0, 8'hf0, dtc_pkg::IDX_HI0, 8'hff, 8'h10);
    wait_flag(1'b0, 260);
    chk(8'(n >= 180 && n <= 204), 8'h01, "16 ticks of 12 clocks");
    wreg(dtc_pkg::IDX_RUN, 8'h20);
    bus(1'b0, dtc_pkg::IDX_HI0, 8'h00, q);
    chk(q, 8'h00, "high byte wrapped");
    bus(1'b0, dtc_pkg::IDX_LO0, 8'h00, q);
    repeat (60) @(posedge clk);
    bus(1'b0, dtc_pkg::IDX_LO0, 8'h00, n[7:0]);
    chk(n[7:0], q, "stopped count holds");
    @(posedge clk) ack0 <= 1'b1;
    @(posedge clk) ack0 <= 1'b0;
    @(posedge clk);
    chk({7'h00, f0}, 8'h00, "flag cleared by service");
  endtask
  task automatic s_reload();
    setup(8'h20, dtc_pkg::IDX_LO1, 8'hfe, dtc_pkg::IDX_HI1, 8'ha0, 8'h40);
    wait_flag(1'b1, 60);
    @(posedge clk) ack1 <= 1'b1;
    @(posedge clk) ack1 <= 1'b0;
    @(posedge clk);
    chk({7'h00, f1}, 8'h00, "flag 1 cleared by service");
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    bus(1'b0, dtc_pkg::IDX_HI1, 8'h00, q);
    chk(q, 8'ha0, "reload source unchanged");
    bus(1'b0, dtc_pkg::IDX_LO1, 8'h00, q);
    chk({q[7:2], 2'b00}, 8'ha0, "low byte reloaded");
  endtask
  task automatic s_mode0();
    setup(8'h00, dtc_pkg::IDX_LO0, 8'hff, dtc_pkg::IDX_HI0, 8'hff, 8'h10);
    wait_flag(1'b0, 40);
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    @(posedge clk);
    chk({7'h00, f0}, 8'h00, "flag cleared by write");
    bus(1'b0, dtc_pkg::IDX_HI0, 8'h00, q);
    chk(q, 8'h00, "13-bit wrap");
    bus(1'b0, dtc_pkg::IDX_LO0, 8'h00, q);
    chk({q[7:5], 5'h00}, 8'he0, "upper bits untouched");
  endtask
  task automatic s_count();
    setup(8'h50, dtc_pkg::IDX_LO1, 8'h00, dtc_pkg::IDX_HI1, 8'h00, 8'h40);
    pm1.pulses(5);
    repeat (48) @(posedge clk);
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    bus(1'b0, dtc_pkg::IDX_LO1, 8'h00, q);
    chk(q, 8'h05, "one step per falling edge");
  endtask
  task automatic s_gate();
    pm0.set_level(1'b0);
    setup(8'h09, dtc_pkg::IDX_LO0, 8'h00, dtc_pkg::IDX_HI0, 8'h00, 8'h10);
    repeat (120) @(posedge clk);
    bus(1'b0, dtc_pkg::IDX_LO0, 8'h00, q);
    chk(q, 8'h00, "gate low blocks");
    pm0.set_level(1'b1);
    repeat (120) @(posedge clk);
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    bus(1'b0, dtc_pkg::IDX_LO0, 8'h00, q);
    chk(8'(q >= 8 && q <= 11), 8'h01, "gate high counts");
  endtask
  // unit 0 split: high byte borrows unit 1 run bit, unit 1 frozen
  task automatic s_split();
    wreg(dtc_pkg::IDX_LO1, 8'h55);
    setup(8'h33, dtc_pkg::IDX_LO0, 8'hfe, dtc_pkg::IDX_HI0, 8'h00, 8'h10);
    wait_flag(1'b0, 48);
    bus(1'b0, dtc_pkg::IDX_HI0, 8'h00, q);
    chk(q, 8'h00, "split high byte idle");
    wreg(dtc_pkg::IDX_RUN, 8'h40);
    repeat (60) @(posedge clk);
    wreg(dtc_pkg::IDX_RUN, 8'h00);
    bus(1'b0, dtc_pkg::IDX_LO1, 8'h00, q);
    chk(q, 8'h55, "unit 1 held");
    bus(1'b0, dtc_pkg::IDX_HI0, 8'h00, q);
    chk(8'(q >= 4 && q <= 6), 8'h01, "split high byte timed");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    s_reset();
    s_timer16();
    s_reload();
    s_mode0();
    s_count();
    s_gate();
    s_split();
    wrap_up();
  end
endmodule // dtc_top_test
`default_nettype wire
